// ==== verilog/rsf_top.sv ====
`include "rsf_params.svh"

module rsf_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire rsf_pkg::rsf_mode_type op_mode,
	input wire rsf_pkg::rsf_event_type events,
	output rsf_pkg::rsf_action_type action,
	output rsf_pkg::rsf_kind_type reset_kind,
	output logic timeout_flag,
	output logic power_down_flag
);
	import rsf_pkg::*;

	localparam int SOFT_DLY = `RSF_SRESET_CYC;

	// ----------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------
	function automatic logic voltage_select_register_valid(input logic [7:0] v);
		return v == `RSF_VOLTAGE_SELECT_REGISTER_POR || v == `RSF_VOLTAGE_SELECT_REGISTER_C1 ||
			v == `RSF_VOLTAGE_SELECT_REGISTER_C2 || v == `RSF_VOLTAGE_SELECT_REGISTER_C3 ||
			v == `RSF_VOLTAGE_SELECT_REGISTER_C4 || v == `RSF_VOLTAGE_SELECT_REGISTER_OFF;
	endfunction : voltage_select_register_valid

	function automatic logic reset_function_control_valid(input logic [7:0] v);
		return v == `RSF_RESET_FUNCTION_CONTROL_POR || v == `RSF_RESET_FUNCTION_CONTROL_PIN;
	endfunction : reset_function_control_valid

	// Every kind but KIND_NONE clears PC and SP; only the sleep timeout spares the rest
	function automatic rsf_action_type action_of(input rsf_kind_type k);
		rsf_action_type a;
		a = '0;
		unique case (k)
			KIND_NONE: a = '0;
			KIND_WDT_SLEEP: a.pc_sp_clear = 1'b1; // [R7] [R16]
			KIND_POR, KIND_PIN, KIND_LVR, KIND_WDT_RUN, KIND_SOFT: begin
				a = '1; // [R11] [R12] [R13] [R14] [R15] [R16] [R17]
			end
			default: a = '0;
		endcase
		return a;
	endfunction : action_of

	// ----------------------------------------------------------
	// State
	// ----------------------------------------------------------
	logic [3:0] flags;
	logic [7:0] reset_function_control;
	logic [7:0] voltage_select_register;
	logic por_pending;
	rsf_tmr_type tmr_state;
	logic [7:0] tmr_cnt;
	logic [7:0] wait_len;

	// ----------------------------------------------------------
	// APB decode
	// ----------------------------------------------------------
	wire apb_setup_done = psel & penable & ~pready;
	wire apb_commit = psel & penable & pready;
	wire wr_en = apb_commit & pwrite;
	wire sel_flags = paddr == `RSF_OFS_FLAGS;
	wire sel_reset_function_control = paddr == `RSF_OFS_RESET_FUNCTION_CONTROL;
	wire sel_voltage_select_register = paddr == `RSF_OFS_VOLTAGE_SELECT_REGISTER;
	wire sel_fc1 = paddr == `RSF_OFS_FC1;
	wire sel_status = paddr == `RSF_OFS_STATUS;
	wire mapped = sel_flags | sel_reset_function_control | sel_voltage_select_register | sel_fc1 | sel_status;
	wire wr_flags = wr_en & sel_flags;
	wire [7:0] status_val = {2'b00, timeout_flag, power_down_flag, 4'h0};
	wire [31:0] read_val = sel_flags ? {28'h0, flags} : // [R4]
		sel_reset_function_control ? {24'h0, reset_function_control} :
		sel_voltage_select_register ? {24'h0, voltage_select_register} :
		sel_status ? {24'h0, status_val} : 32'h0;

	// ----------------------------------------------------------
	// Reset sources; next_kind ranks them highest priority first, flash trigger above LVR and pin
	// ----------------------------------------------------------
	wire run_mode = op_mode == MODE_FAST || op_mode == MODE_SLOW;
	// Detector is off in idle or sleep mode or when software disabled it
	wire lvr_hit = events.lvr_low & run_mode & (voltage_select_register != `RSF_VOLTAGE_SELECT_REGISTER_OFF);
	wire pin_hit = events.pin_low & (reset_function_control == `RSF_RESET_FUNCTION_CONTROL_PIN);
	wire fc1_hit = wr_en & sel_fc1 & (pwdata[7:0] == `RSF_FC1_TRIG); // [R5]
	wire reset_function_control_bad = ~reset_function_control_valid(reset_function_control);
	wire voltage_select_register_bad = ~voltage_select_register_valid(voltage_select_register);
	wire any_bad = reset_function_control_bad | voltage_select_register_bad;
	wire soft_fire = tmr_state == TMR_WAIT && tmr_cnt == 8'h00 && any_bad;
	wire wdt_run_hit = events.wdt_timeout & run_mode;
	wire wdt_sleep_hit = events.wdt_timeout & ~run_mode;

	wire rsf_kind_type next_kind = por_pending ? KIND_POR :
		fc1_hit ? KIND_SOFT :
		lvr_hit ? KIND_LVR :
		pin_hit ? KIND_PIN :
		(soft_fire | events.wdt_ctrl_error) ? KIND_SOFT :
		wdt_run_hit ? KIND_WDT_RUN :
		wdt_sleep_hit ? KIND_WDT_SLEEP : KIND_NONE;
	wire full_now = next_kind != KIND_NONE && next_kind != KIND_WDT_SLEEP;
	// The supply level survives its own reset, so LVR keeps it
	wire voltage_select_register_restore = full_now && next_kind != KIND_LVR;

	// ----------------------------------------------------------
	// Next values
	// ----------------------------------------------------------
	wire [3:0] flags_sw = wr_flags ? pwdata[3:0] : flags; // [R3]
	wire [3:0] flags_hw = {soft_fire & reset_function_control_bad, // [R19]
		next_kind == KIND_LVR, // [R1] [R18]
		soft_fire & voltage_select_register_bad, // [R2] [R21]
		events.wdt_ctrl_error};
	// Hardware set beats a simultaneous software clear
	wire [3:0] next_flags = flags_sw | flags_hw; // [R3]
	wire [7:0] next_reset_function_control = full_now ? `RSF_RESET_FUNCTION_CONTROL_POR :
		(wr_en & sel_reset_function_control) ? pwdata[7:0] : reset_function_control;
	wire [7:0] next_voltage_select_register = voltage_select_register_restore ? `RSF_VOLTAGE_SELECT_REGISTER_POR : // [R21]
		(wr_en & sel_voltage_select_register) ? pwdata[7:0] : voltage_select_register;
	wire to_set = next_kind == KIND_WDT_RUN || // [R6]
		next_kind == KIND_WDT_SLEEP; // [R7]
	wire pdf_set = next_kind == KIND_WDT_SLEEP || // [R9]
		events.sleep_entry;
	// Pin, LVR and soft kinds fall through and keep both bits
	wire next_to = to_set | (timeout_flag & ~events.clr_wdt); // [R8]
	wire next_pdf = pdf_set | (power_down_flag & ~events.clr_wdt); // [R9]

	// ----------------------------------------------------------
	// Bus slave: one wait state, data and error registered
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= apb_setup_done;
			prdata <= apb_setup_done ? read_val : 32'h0;
			pslverr <= apb_setup_done & ~mapped;
		end
	end

	// ----------------------------------------------------------
	// Registers and flags
	// ----------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags <= `RSF_FLAGS_POR;
			reset_function_control <= `RSF_RESET_FUNCTION_CONTROL_POR;
			voltage_select_register <= `RSF_VOLTAGE_SELECT_REGISTER_POR;
			timeout_flag <= 1'b0; // [R10]
			power_down_flag <= 1'b0; // [R10]
		end else begin
			flags <= next_flags;
			reset_function_control <= next_reset_function_control;
			voltage_select_register <= next_voltage_select_register;
			timeout_flag <= next_to;
			power_down_flag <= next_pdf;
		end
	end

	// ----------------------------------------------------------
	// Reset outputs
	// ----------------------------------------------------------
	// Power-on effects fire once, on the first edge after release
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_pending <= 1'b1;
			reset_kind <= KIND_NONE;
			action <= '0;
		end else begin
			por_pending <= 1'b0;
			reset_kind <= next_kind;
			action <= action_of(next_kind); // [R16] [R17]
		end
	end

	// ----------------------------------------------------------
	// Corruption delay timer
	// ----------------------------------------------------------
	// A value corrected before the delay ends cancels the reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tmr_state <= TMR_IDLE;
			tmr_cnt <= 8'h00;
		end else begin
			unique case (tmr_state)
				TMR_IDLE: begin
					if (any_bad && !full_now) begin
						tmr_state <= TMR_WAIT; // [R20]
						tmr_cnt <= 8'(SOFT_DLY - 1);
					end
				end
				TMR_WAIT: begin
					if (!any_bad || full_now || tmr_cnt == 8'h00) begin
						tmr_state <= TMR_IDLE;
					end else begin
						tmr_cnt <= tmr_cnt - 8'h01;
					end
				end
			endcase
		end
	end

	// Helper for checks: cycles spent waiting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wait_len <= 8'h00;
		end else begin
			wait_len <= (tmr_state == TMR_WAIT) ? wait_len + 8'h01 : 8'h00;
		end
	end

	// ----------------------------------------------------------
	// Checks
	// ----------------------------------------------------------
	sequence read_flags_s;
		psel && penable && !pready && !pwrite && sel_flags;
	endsequence

	sequence sleep_to_s;
		next_kind == KIND_WDT_SLEEP;
	endsequence

	sequence por_release_s;
		por_pending ##1 !por_pending;
	endsequence

	a_flags_upper_zero: assert property ( // [R4]
		@(posedge pclk) disable iff (!presetn)
		read_flags_s |=> pready && prdata[31:4] == 28'h0)
		else $error("flag read shows upper bits set");

	a_lvr_flag_set: assert property ( // [R1] [R18]
		@(posedge pclk) disable iff (!presetn)
		lvr_hit && !por_pending && !fc1_hit |=>
			reset_kind == KIND_LVR && flags[`RSF_BIT_LOW_VOLTAGE_RESET_FLAG] &&
			flags[`RSF_BIT_CTRL_REG_SW_RESET_FLAG] == $past(flags[`RSF_BIT_CTRL_REG_SW_RESET_FLAG]))
		else $error("LVR reset did not set only its flag");

	a_lrf_restore: assert property ( // [R2] [R21]
		@(posedge pclk) disable iff (!presetn)
		soft_fire && voltage_select_register_bad |=> flags[`RSF_BIT_LRF] &&
			voltage_select_register == `RSF_VOLTAGE_SELECT_REGISTER_POR)
		else $error("bad voltage code not flagged or restored");

	a_flag_no_hw_clr: assert property ( // [R3]
		@(posedge pclk) disable iff (!presetn)
		$fell(flags[`RSF_BIT_LOW_VOLTAGE_RESET_FLAG]) || $fell(flags[`RSF_BIT_LRF]) |->
			$past(wr_flags))
		else $error("flag cleared without software write");

	a_fc1_device_reset: assert property ( // [R5]
		@(posedge pclk) disable iff (!presetn)
		fc1_hit && !por_pending |=> reset_kind == KIND_SOFT &&
			action.ptr_clear && action.pc_sp_clear)
		else $error("flash control trigger gave no reset");

	a_wdt_run_flags: assert property ( // [R6] [R9]
		@(posedge pclk) disable iff (!presetn)
		next_kind == KIND_WDT_RUN && !events.sleep_entry &&
			!events.clr_wdt |=>
			timeout_flag && power_down_flag == $past(power_down_flag))
		else $error("running timeout flags wrong");

	a_wdt_sleep_warm: assert property ( // [R7] [R9] [R17]
		@(posedge pclk) disable iff (!presetn)
		sleep_to_s |=> timeout_flag && power_down_flag &&
			action.pc_sp_clear && !action.ptr_clear &&
			!action.int_disable && $stable(reset_function_control))
		else $error("sleep timeout disturbed other state");

	a_pin_keeps_flags: assert property ( // [R8]
		@(posedge pclk) disable iff (!presetn)
		next_kind == KIND_PIN && !events.clr_wdt && !events.sleep_entry
			|=> $stable(timeout_flag) && $stable(power_down_flag) &&
			reset_kind == KIND_PIN)
		else $error("pin reset changed timeout or power-down");

	a_por_sequence: assert property ( // [R10] [R11] [R12] [R13] [R14] [R15]
		@(posedge pclk) disable iff (!presetn)
		por_release_s |-> reset_kind == KIND_POR && action == '1 &&
			!$past(timeout_flag))
		else $error("power-on actions missing");

	a_soft_delay: assert property ( // [R20]
		@(posedge pclk) disable iff (!presetn)
		soft_fire |-> wait_len == 8'(SOFT_DLY - 1) ##1
			reset_kind != KIND_NONE)
		else $error("corrupted control reset at wrong time");

	a_ctrl_reg_sw_reset_flag_set: assert property ( // [R19]
		@(posedge pclk) disable iff (!presetn)
		soft_fire && reset_function_control_bad |=> flags[`RSF_BIT_CTRL_REG_SW_RESET_FLAG] &&
			reset_function_control == `RSF_RESET_FUNCTION_CONTROL_POR)
		else $error("reset control corruption not flagged");

	a_pc_always: assert property ( // [R16]
		@(posedge pclk) disable iff (!presetn)
		next_kind != KIND_NONE |=> action.pc_sp_clear)
		else $error("reset without program counter clear");

	a_lvr_keeps_flags: assert property ( // [R8]
		@(posedge pclk) disable iff (!presetn)
		next_kind == KIND_LVR && !events.clr_wdt && !events.sleep_entry
			|=> $stable(timeout_flag) && $stable(power_down_flag))
		else $error("LVR reset changed timeout or power-down");

	a_por_flags_zero: assert property ( // [R10]
		@(posedge pclk) disable iff (!presetn)
		por_pending && events == '0 |=>
			!timeout_flag && !power_down_flag)
		else $error("power-on left timeout or power-down set");

	a_flag_sw_write: assert property ( // [R3]
		@(posedge pclk) disable iff (!presetn)
		wr_flags && flags_hw == 4'h0 |=> flags == $past(pwdata[3:0]))
		else $error("flag write did not land");

	a_flag_hw_wins: assert property ( // [R3]
		@(posedge pclk) disable iff (!presetn)
		flags_hw[`RSF_BIT_LOW_VOLTAGE_RESET_FLAG] |=> flags[`RSF_BIT_LOW_VOLTAGE_RESET_FLAG])
		else $error("software clear beat hardware set");

	a_lvr_sleep_off: assert property ( // [R1]
		@(posedge pclk) disable iff (!presetn)
		events.lvr_low && !run_mode |=> reset_kind != KIND_LVR)
		else $error("LVR acted while sleeping or idle");

	a_soft_cancel: assert property ( // [R20]
		@(posedge pclk) disable iff (!presetn)
		tmr_state == TMR_WAIT && !any_bad |=> tmr_state == TMR_IDLE)
		else $error("corrected control value did not cancel");

	a_reset_function_control_restore: assert property ( // [R20]
		@(posedge pclk) disable iff (!presetn)
		full_now |=> reset_function_control == `RSF_RESET_FUNCTION_CONTROL_POR)
		else $error("full reset did not restore reset control");

	a_lvr_keeps_voltage_select_register: assert property ( // [R21]
		@(posedge pclk) disable iff (!presetn)
		next_kind == KIND_LVR && !(wr_en && sel_voltage_select_register) |=> $stable(voltage_select_register))
		else $error("LVR reset changed voltage selection");

	a_por_actions: assert property ( // [R11] [R12] [R13] [R14]
		@(posedge pclk) disable iff (!presetn)
		next_kind == KIND_POR |=> action.int_disable &&
			action.wdt_clear && action.timers_off && action.ports_input)
		else $error("power-on actions incomplete");
endmodule : rsf_top

// ==== common/rsf_params.svh ====
`ifndef RSF_PARAMS_SVH
`define RSF_PARAMS_SVH
// Functional notes
// (R1) Low-voltage reset sets flag bit 2
// (R2) Undefined voltage-select code sets bit 1
// (R3) Flags cleared only by software writing zero
// (R4) Flag bits 7 to 4 read zero
// (R5) Flash control write 55h resets device
// (R6) Running-mode watchdog timeout sets timeout flag
// (R7) Sleep/idle timeout clears only PC, SP
// (R8) Pin or LVR reset keeps timeout, power-down
// (R9) Timeout keeps POWER_DOWN_FLAG running; sets both sleeping
// (R10) Power-on clears timeout and power-down flags
// (R11) Power-on disables all interrupts
// (R12) Power-on clears watchdog, time base; counts
// (R13) Power-on switches timers off
// (R14) Power-on makes every port an input
// (R15) Power-on zeroes PC, stack at top
// (R16) Every reset clears program counter low
// (R17) Pointers cleared except sleep-mode timeout
// (R18) LVR sets only its flag; others keep
// (R19) Invalid reset-control value sets bit 3
// (R20) Reset-control not 55h/aah resets after delay
// (R21) Defined voltage codes; others reset, restore

// Register byte offsets
`define RSF_OFS_FLAGS 8'h00
`define RSF_OFS_RESET_FUNCTION_CONTROL 8'h04
`define RSF_OFS_VOLTAGE_SELECT_REGISTER 8'h08
`define RSF_OFS_FC1 8'h0c
`define RSF_OFS_STATUS 8'h10

// Field positions
`define RSF_BIT_WRF 0
`define RSF_BIT_LRF 1
`define RSF_BIT_LOW_VOLTAGE_RESET_FLAG 2
`define RSF_BIT_CTRL_REG_SW_RESET_FLAG 3
`define RSF_BIT_PDF 4
`define RSF_BIT_TO 5

// Reset values and codes
`define RSF_FLAGS_POR 4'h0
`define RSF_RESET_FUNCTION_CONTROL_POR 8'h55
`define RSF_RESET_FUNCTION_CONTROL_PIN 8'haa
`define RSF_VOLTAGE_SELECT_REGISTER_POR 8'h66
`define RSF_VOLTAGE_SELECT_REGISTER_C1 8'h55
`define RSF_VOLTAGE_SELECT_REGISTER_C2 8'h33
`define RSF_VOLTAGE_SELECT_REGISTER_C3 8'h99
`define RSF_VOLTAGE_SELECT_REGISTER_C4 8'haa
`define RSF_VOLTAGE_SELECT_REGISTER_OFF 8'hf0
`define RSF_FC1_TRIG 8'h55

// Delay before a corrupted control register resets the device
`define RSF_CLK_NS 10
`define RSF_SRESET_NS 100
`define RSF_SRESET_CYC ((`RSF_SRESET_NS + `RSF_CLK_NS - 1) / `RSF_CLK_NS)
`endif

// ==== common/rsf_pkg.sv ====
package rsf_pkg;
	typedef enum logic [1:0] {
		MODE_FAST = 2'b00,
		MODE_SLOW = 2'b01,
		MODE_IDLE = 2'b10,
		MODE_SLEEP = 2'b11
	} rsf_mode_type;

	typedef enum logic [2:0] {
		KIND_NONE = 3'b000,
		KIND_POR = 3'b001,
		KIND_PIN = 3'b010,
		KIND_LVR = 3'b011,
		KIND_WDT_RUN = 3'b100,
		KIND_WDT_SLEEP = 3'b101,
		KIND_SOFT = 3'b110
	} rsf_kind_type;

	typedef enum logic [1:0] {
		TMR_IDLE = 2'b00,
		TMR_WAIT = 2'b01
	} rsf_tmr_type;

	typedef struct packed {
		logic lvr_low;
		logic pin_low;
		logic wdt_timeout;
		logic wdt_ctrl_error;
		logic sleep_entry;
		logic clr_wdt;
	} rsf_event_type;

	typedef struct packed {
		logic pc_sp_clear;
		logic ptr_clear;
		logic int_disable;
		logic wdt_clear;
		logic timers_off;
		logic ports_input;
	} rsf_action_type;
endpackage : rsf_pkg

// ==== verification/reset_source_flags_tb.sv ====
`include "rsf_params.svh"

module reset_source_flags_tb;
	timeunit 1ns;
	timeprecision 100ps;
	import rsf_pkg::*;

	// ----------------------------------------
	// Signals and model state
	// ----------------------------------------
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv;
	rsf_mode_type op_mode;
	rsf_event_type events;
	rsf_action_type action, seen_a;
	rsf_kind_type reset_kind, seen_k;
	logic timeout_flag, power_down_flag, mto, mpdf;
	logic [3:0] mflags;
	int n_errors, n_compared, n_seen;
	logic [7:0] codes [6] = '{8'h66, 8'h55, 8'h33, 8'h99, 8'haa, 8'hf0};

	rsf_top dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .op_mode(op_mode),
		.events(events), .action(action), .reset_kind(reset_kind),
		.timeout_flag(timeout_flag), .power_down_flag(power_down_flag)
	);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// Latches any reset pulse so checks need not hit its single cycle
	always @(posedge pclk) begin
		if (reset_kind !== KIND_NONE) begin
			seen_k <= reset_kind;
			seen_a <= action;
			n_seen <= n_seen + 1;
		end
	end

	// ----------------------------------------
	// Expectations
	// ----------------------------------------
	function automatic logic [1:0] exp_tp(input rsf_kind_type k,
			input logic [1:0] c);
		case (k)
			KIND_POR: return 2'b00;
			KIND_WDT_RUN: return {1'b1, c[0]};
			KIND_WDT_SLEEP: return 2'b11;
			default: return c;
		endcase
	endfunction : exp_tp

	function automatic rsf_action_type exp_act(input rsf_kind_type k);
		return (k == KIND_WDT_SLEEP) ? 6'b100000 : 6'b111111;
	endfunction : exp_act

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int t;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (pready !== 1'b1 && t < 20);
		if (pready !== 1'b1) n_errors++;
		rdv = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rdv, exp);
	endtask : rd

	task automatic hold(input int n);
		repeat (n) @(posedge pclk);
	endtask : hold

	task automatic clr_seen;
		@(posedge pclk);
		seen_k <= KIND_NONE;
		seen_a <= '0;
		n_seen <= 0;
	endtask : clr_seen

	task automatic tdone(input string s);
		$display("test %s done", s);
	endtask : tdone

	task automatic run_evt(input rsf_event_type ev, input rsf_mode_type m,
			input rsf_kind_type k);
		clr_seen();
		op_mode <= m;
		@(posedge pclk);
		events <= ev;
		@(posedge pclk);
		events <= '0;
		hold(3);
		chk(seen_k, k);
		chk(n_seen, (k == KIND_NONE) ? 0 : 1);
		if (k != KIND_NONE) chk(seen_a, exp_act(k));
		{mto, mpdf} = exp_tp(k, {mto, mpdf});
		if (k == KIND_LVR) mflags[2] = 1'b1;
		chk({timeout_flag, power_down_flag}, {mto, mpdf});
		rd(`RSF_OFS_FLAGS, {28'h0, mflags});
	endtask : run_evt

	task automatic finish_test;
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : finish_test

	initial begin
		#200000;
		n_errors++;
		finish_test();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		int v;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		op_mode = MODE_FAST;
		events = '0;
		seen_k = KIND_NONE;
		seen_a = '0;
		n_seen = 0;
		n_errors = 0;
		n_compared = 0;
		mflags = 4'h0;
		mto = 1'b0;
		mpdf = 1'b0;
		v = $urandom(32'hf091c0f0);
		hold(5);
		presetn <= 1'b1;
		hold(3);
		chk(seen_k, KIND_POR);
		chk(seen_a, 6'h3f);
		chk({timeout_flag, power_down_flag}, 2'b00);
		rd(`RSF_OFS_FLAGS, 32'h0);
		rd(`RSF_OFS_RESET_FUNCTION_CONTROL, 32'h55);
		rd(`RSF_OFS_VOLTAGE_SELECT_REGISTER, 32'h66);
		apb(1'b0, 8'h20, 32'h0);
		chk(err, 1'b1);
		chk(rdv, 32'h0);
		repeat (4) begin
			v = $urandom;
			apb(1'b1, `RSF_OFS_FLAGS, v);
			mflags = v[3:0];
			rd(`RSF_OFS_FLAGS, {28'h0, mflags});
		end
		tdone("registers");
		v = $urandom_range(1, 0);
		run_evt(6'b001000, rsf_mode_type'(v[1:0]), KIND_WDT_RUN);
		run_evt(6'b100000, MODE_SLOW, KIND_LVR);
		run_evt(6'b100000, MODE_IDLE, KIND_NONE);
		run_evt(6'b010000, MODE_FAST, KIND_NONE);
		apb(1'b1, `RSF_OFS_RESET_FUNCTION_CONTROL, 32'haa);
		run_evt(6'b010000, MODE_FAST, KIND_PIN);
		rd(`RSF_OFS_RESET_FUNCTION_CONTROL, 32'h55);
		mpdf = 1'b1;
		run_evt(6'b000010, MODE_SLEEP, KIND_NONE);
		v = $urandom_range(3, 2);
		run_evt(6'b001000, rsf_mode_type'(v[1:0]), KIND_WDT_SLEEP);
		{mto, mpdf} = 2'b00;
		run_evt(6'b000001, MODE_FAST, KIND_NONE);
		tdone("events");
		clr_seen();
		apb(1'b1, `RSF_OFS_FC1, 32'h54);
		hold(3);
		chk(n_seen, 0);
		apb(1'b1, `RSF_OFS_FC1, 32'h55);
		hold(3);
		chk(seen_k, KIND_SOFT);
		tdone("flash");
		v = $urandom_range(255, 0);
		if (v == 8'h55 || v == 8'haa) v = 8'h12;
		clr_seen();
		apb(1'b1, `RSF_OFS_RESET_FUNCTION_CONTROL, v);
		apb(1'b1, `RSF_OFS_RESET_FUNCTION_CONTROL, 32'h55);
		hold(20);
		chk(n_seen, 0);
		apb(1'b1, `RSF_OFS_RESET_FUNCTION_CONTROL, v);
		hold(20);
		chk(seen_k, KIND_SOFT);
		mflags[3] = 1'b1;
		rd(`RSF_OFS_FLAGS, {28'h0, mflags});
		rd(`RSF_OFS_RESET_FUNCTION_CONTROL, 32'h55);
		foreach (codes[i]) begin
			clr_seen();
			apb(1'b1, `RSF_OFS_VOLTAGE_SELECT_REGISTER, {24'h0, codes[i]});
			hold(15);
			chk(n_seen, 0);
			rd(`RSF_OFS_VOLTAGE_SELECT_REGISTER, {24'h0, codes[i]});
		end
		clr_seen();
		apb(1'b1, `RSF_OFS_VOLTAGE_SELECT_REGISTER, 32'h77);
		hold(20);
		chk(seen_k, KIND_SOFT);
		mflags[1] = 1'b1;
		rd(`RSF_OFS_FLAGS, {28'h0, mflags});
		rd(`RSF_OFS_VOLTAGE_SELECT_REGISTER, 32'h66);
		tdone("corruption");
		run_evt(6'b001000, MODE_SLEEP, KIND_WDT_SLEEP);
		clr_seen();
		presetn <= 1'b0;
		hold(2);
		presetn <= 1'b1;
		hold(3);
		chk(seen_k, KIND_POR);
		chk({timeout_flag, power_down_flag}, 2'b00);
		rd(`RSF_OFS_FLAGS, 32'h0);
		tdone("power_on");
		finish_test();
	end
endmodule : reset_source_flags_tb
